/* core/iag_pkg.sv */
// Contract
// - Two independent integer address units generate addresses and update pointers.
// - Each unit owns a private 31-word register file.
// - Immediate and indirect addressing: pre-modify without pointer update, post-modify with pointer update.
// - Modulus and bit-reverse addressing with no buffer placement restriction.
// - Each access is tagged single, dual or quad word.
// - Each unit holds four circular buffer sets, eight in total.
// - Circular pointers wrap in hardware when passing the buffer end.
// - Circular buffers may begin and end at any address.
// - Integer pipeline is one stage; results usable next cycle.
// - Dependency checker stalls issue when a needed result is not ready; here both units hold one cycle when one names the other's result register.
// - Units execute general integer arithmetic and logic on their registers.
// - Hardware support for zero-overhead loop counting.
package iag_pkg;
  localparam int unsigned IAG_W      = 32;
  localparam int unsigned IAG_RWORDS = 31;
  localparam int unsigned IAG_RA_W   = 5;
  localparam int unsigned IAG_NCIRC  = 4;
  localparam int unsigned IAG_CI_W   = 2;
  localparam int unsigned IAG_NUNITS = 2;
  localparam logic [IAG_RA_W-1:0] IAG_NO_REG = 5'h1f;
  localparam logic [IAG_W-1:0]    IAG_ZERO   = 32'h0000_0000;
  localparam logic [IAG_W-1:0]    IAG_ONE    = 32'h0000_0001;

  // Operation codes issued to a unit
  typedef enum logic [3:0] {
    IAG_OP_NOP  = 4'h0,
    IAG_OP_ADD  = 4'h1,
    IAG_OP_SUB  = 4'h2,
    IAG_OP_AND  = 4'h3,
    IAG_OP_OR   = 4'h4,
    IAG_OP_XOR  = 4'h5,
    IAG_OP_MOVI = 4'h6,
    IAG_OP_AIMM = 4'h7,
    IAG_OP_APRE = 4'h8,
    IAG_OP_APST = 4'h9,
    IAG_OP_SETB = 4'ha,
    IAG_OP_SETL = 4'hb,
    IAG_OP_LSET = 4'hc,
    IAG_OP_LDEC = 4'hd
  } iag_op_e;

  // Address modes for pointer arithmetic
  typedef enum logic [1:0] {
    IAG_AM_LIN  = 2'h0,
    IAG_AM_CIRC = 2'h1,
    IAG_AM_BREV = 2'h2
  } iag_am_e;

  // Transfer size tags
  typedef enum logic [1:0] {
    IAG_SZ_SINGLE = 2'h0,
    IAG_SZ_DUAL   = 2'h1,
    IAG_SZ_QUAD   = 2'h2
  } iag_sz_e;

  typedef struct packed {
    logic                valid;
    iag_op_e             op;
    iag_am_e             amode;
    iag_sz_e             size;
    logic [IAG_CI_W-1:0] cbuf;
    logic [IAG_RA_W-1:0] rd;
    logic [IAG_RA_W-1:0] ra;
    logic [IAG_RA_W-1:0] rb;
    logic [IAG_W-1:0]    imm;
  } iag_instr_s;

  typedef struct packed {
    logic             valid;
    logic [IAG_W-1:0] addr;
    iag_sz_e          size;
  } iag_mem_s;
endpackage

/* core/iag_top.sv */
`timescale 1ns/1ps
module iag_top (
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  iag_pkg::iag_instr_s      instr0,
  input  iag_pkg::iag_instr_s      instr1,
  output iag_pkg::iag_mem_s        mem0,
  output iag_pkg::iag_mem_s        mem1,
  output logic [iag_pkg::IAG_W-1:0] result0,
  output logic [iag_pkg::IAG_W-1:0] result1,
  output logic                     stall,
  output logic [1:0]               loop_done
);
  localparam int unsigned NU = iag_pkg::IAG_NUNITS;
  localparam int unsigned W  = iag_pkg::IAG_W;

  // Bit-reverse of the whole 32-bit word
  function automatic logic [W-1:0] brev(input logic [W-1:0] v);
    logic [W-1:0] r;
    r = '0;
    for (int i = 0; i < W; i++) begin
      r[i] = v[W-1-i];
    end
    return r;
  endfunction

  // Pointer update per mode; circular wraps against base and length
  function automatic logic [W-1:0] modify(
    input logic [W-1:0] p, input logic [W-1:0] m, input iag_pkg::iag_am_e am,
    input logic [W-1:0] b, input logic [W-1:0] l);
    logic [W-1:0] s;
    s = p + m;
    if (am == iag_pkg::IAG_AM_BREV) begin
      s = brev(brev(p) + brev(m));
    end else if (am == iag_pkg::IAG_AM_CIRC && l != iag_pkg::IAG_ZERO) begin
      if ($signed(s - b) >= $signed(l)) begin
        s = s - l;
      end else if ($signed(s - b) < 0) begin
        s = s + l;
      end
    end
    return s;
  endfunction

  iag_pkg::iag_instr_s in_u [NU];
  assign in_u[0] = instr0;
  assign in_u[1] = instr1;

  // Per-unit state
  logic [W-1:0] rf_reg   [NU][iag_pkg::IAG_RWORDS];
  logic [W-1:0] rf_next  [NU][iag_pkg::IAG_RWORDS];
  logic [W-1:0] base_reg [NU][iag_pkg::IAG_NCIRC];
  logic [W-1:0] base_next[NU][iag_pkg::IAG_NCIRC];
  logic [W-1:0] len_reg  [NU][iag_pkg::IAG_NCIRC];
  logic [W-1:0] len_next [NU][iag_pkg::IAG_NCIRC];
  logic [W-1:0] lcnt_reg [NU];
  logic [W-1:0] lcnt_next[NU];
  iag_pkg::iag_mem_s mem_reg [NU];
  iag_pkg::iag_mem_s mem_next[NU];
  logic [W-1:0] res_reg  [NU];
  logic [W-1:0] res_next [NU];
  logic [1:0]   done_reg, done_next;
  logic         stall_reg, stall_next;
  logic         hz_reg, hz_next;
  logic [iag_pkg::IAG_RA_W-1:0] pend_reg [NU];
  logic [iag_pkg::IAG_RA_W-1:0] pend_next[NU];

  // Operand match: a valid instruction that reads register r through ra or rb
  function automatic logic uses(input iag_pkg::iag_instr_s x,
                                input logic [iag_pkg::IAG_RA_W-1:0] r);
    return x.valid && r != iag_pkg::IAG_NO_REG && (x.ra == r || x.rb == r);
  endfunction

  // Dependency check: when a unit names the other unit's result register of this
  // cycle as an operand, both units hold issue one cycle; each still reads only its own file.
  always_comb begin
    hz_next = 1'b0;
    if (!hz_reg) begin
      for (int u = 0; u < NU; u++) begin
        if (in_u[u].valid && in_u[u].rd != iag_pkg::IAG_NO_REG &&
            uses(in_u[NU-1-u], in_u[u].rd)) begin
          hz_next = 1'b1;
        end
      end
    end
    stall_next = hz_next;
  end

  // Execution of both units; each reads only its own register file
  always_comb begin
    logic [W-1:0] a, b, ea, np;
    a = '0;
    b = '0;
    ea = '0;
    np = '0;
    done_next = 2'h0;
    for (int u = 0; u < NU; u++) begin
      rf_next[u]   = rf_reg[u];
      base_next[u] = base_reg[u];
      len_next[u]  = len_reg[u];
      lcnt_next[u] = lcnt_reg[u];
      res_next[u]  = res_reg[u];
      pend_next[u] = iag_pkg::IAG_NO_REG;
      mem_next[u]  = '{valid: 1'b0, addr: mem_reg[u].addr, size: mem_reg[u].size};
      if (in_u[u].valid && !hz_next) begin
        a = (in_u[u].ra == iag_pkg::IAG_NO_REG) ? iag_pkg::IAG_ZERO : rf_reg[u][in_u[u].ra];
        b = (in_u[u].rb == iag_pkg::IAG_NO_REG) ? in_u[u].imm : rf_reg[u][in_u[u].rb];
        np = modify(a, b, in_u[u].amode, base_reg[u][in_u[u].cbuf],
                    len_reg[u][in_u[u].cbuf]);
        ea = a;
        unique case (in_u[u].op)
          iag_pkg::IAG_OP_NOP:  ea = a;
          iag_pkg::IAG_OP_ADD:  ea = a + b;
          iag_pkg::IAG_OP_SUB:  ea = a - b;
          iag_pkg::IAG_OP_AND:  ea = a & b;
          iag_pkg::IAG_OP_OR:   ea = a | b;
          iag_pkg::IAG_OP_XOR:  ea = a ^ b;
          iag_pkg::IAG_OP_MOVI: ea = in_u[u].imm;
          iag_pkg::IAG_OP_AIMM: begin
            mem_next[u] = '{valid: 1'b1, addr: in_u[u].imm, size: in_u[u].size};
          end
          iag_pkg::IAG_OP_APRE: begin
            mem_next[u] = '{valid: 1'b1, addr: np, size: in_u[u].size};
          end
          iag_pkg::IAG_OP_APST: begin
            mem_next[u] = '{valid: 1'b1, addr: a, size: in_u[u].size};
            if (in_u[u].ra != iag_pkg::IAG_NO_REG) begin
              rf_next[u][in_u[u].ra] = np;
            end
          end
          iag_pkg::IAG_OP_SETB: base_next[u][in_u[u].cbuf] = b;
          iag_pkg::IAG_OP_SETL: len_next[u][in_u[u].cbuf] = b;
          iag_pkg::IAG_OP_LSET: lcnt_next[u] = b;
          iag_pkg::IAG_OP_LDEC: begin
            if (lcnt_reg[u] != iag_pkg::IAG_ZERO) begin
              lcnt_next[u] = lcnt_reg[u] - iag_pkg::IAG_ONE;
            end
            done_next[u] = (lcnt_reg[u] == iag_pkg::IAG_ONE);
          end
          default: ea = a;
        endcase
        if (in_u[u].op inside {iag_pkg::IAG_OP_ADD, iag_pkg::IAG_OP_SUB,
            iag_pkg::IAG_OP_AND, iag_pkg::IAG_OP_OR, iag_pkg::IAG_OP_XOR,
            iag_pkg::IAG_OP_MOVI} && in_u[u].rd != iag_pkg::IAG_NO_REG) begin
          rf_next[u][in_u[u].rd] = ea;
          res_next[u] = ea;
          pend_next[u] = in_u[u].rd;
        end
      end
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int u = 0; u < NU; u++) begin
        for (int i = 0; i < iag_pkg::IAG_RWORDS; i++) begin
          rf_reg[u][i] <= '0;
        end
        for (int c = 0; c < iag_pkg::IAG_NCIRC; c++) begin
          base_reg[u][c] <= '0;
          len_reg[u][c]  <= '0;
        end
        lcnt_reg[u] <= '0;
        res_reg[u]  <= '0;
        pend_reg[u] <= iag_pkg::IAG_NO_REG;
        mem_reg[u]  <= '0;
      end
      done_reg  <= 2'h0;
      stall_reg <= 1'b0;
      hz_reg    <= 1'b0;
    end else begin
      rf_reg    <= rf_next;
      base_reg  <= base_next;
      len_reg   <= len_next;
      lcnt_reg  <= lcnt_next;
      res_reg   <= res_next;
      pend_reg  <= pend_next;
      mem_reg   <= mem_next;
      done_reg  <= done_next;
      stall_reg <= stall_next;
      hz_reg    <= hz_next;
    end
  end

  assign mem0      = mem_reg[0];
  assign mem1      = mem_reg[1];
  assign result0   = res_reg[0];
  assign result1   = res_reg[1];
  assign stall     = stall_reg;
  assign loop_done = done_reg;
endmodule // iag_top

/* tb/iag_mem_bank.sv */
`timescale 1ns/1ps
module iag_mem_bank (
  input wire logic         sys_clk,
  input wire logic         srst,
  input iag_pkg::iag_mem_s req,
  output logic [7:0]       n_acc
);
  // Bank takes one access per cycle and counts them
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      n_acc <= 8'h00;
    end else if (req.valid) begin
      n_acc <= n_acc + 8'h01;
    end
  end
endmodule // iag_mem_bank

/* tb/iag_props.sv */
`timescale 1ns/1ps
module iag_props (
  input wire logic                  sys_clk,
  input wire logic                  srst,
  input iag_pkg::iag_instr_s        instr0,
  input iag_pkg::iag_instr_s        instr1,
  input iag_pkg::iag_mem_s          mem0,
  input iag_pkg::iag_mem_s          mem1,
  input wire logic [iag_pkg::IAG_W-1:0] result0,
  input wire logic                  stall,
  input wire logic [1:0]            loop_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Lone immediate access on either unit
  sequence s_imm0;
    instr0.valid && instr0.op == iag_pkg::IAG_OP_AIMM && !instr1.valid;
  endsequence
  sequence s_imm1;
    instr1.valid && instr1.op == iag_pkg::IAG_OP_AIMM && !instr0.valid;
  endsequence
  chk_imm_addr: assert property (s_imm0 |=> mem0.valid && mem0.addr == $past(instr0.imm))
    else $error("imm address wrong");
  chk_imm_size: assert property (s_imm0 |=> mem0.size == $past(instr0.size))
    else $error("size tag wrong");
  chk_unit_one: assert property (s_imm1 |=> mem1.valid && mem1.addr == $past(instr1.imm))
    else $error("unit one address wrong");
  chk_alu_add: assert property (instr0.valid && instr0.op == iag_pkg::IAG_OP_ADD
    && instr0.ra == 5'h1f && instr0.rb == 5'h1f && instr0.rd != 5'h1f && !instr1.valid
    |=> result0 == $past(instr0.imm)) else $error("add result wrong");
  chk_stall_once: assert property (stall |=> !stall)
    else $error("stall repeated");
  chk_hazard_stall: assert property (instr0.valid && instr0.op == iag_pkg::IAG_OP_ADD
    && instr0.rd != 5'h1f && instr1.valid && instr1.ra == instr0.rd && !stall
    |=> stall && !mem1.valid) else $error("hazard missed");
  chk_no_access: assert property (!(instr0.valid && instr0.op inside {iag_pkg::IAG_OP_AIMM,
    iag_pkg::IAG_OP_APRE, iag_pkg::IAG_OP_APST}) |=> !mem0.valid) else $error("stray access");
  chk_loop_cause: assert property (loop_done[0] |-> $past(instr0.op) == iag_pkg::IAG_OP_LDEC)
    else $error("loop pulse without decrement");
endmodule // iag_props
bind iag_top iag_props u_props (.sys_clk(sys_clk), .srst(srst), .instr0(instr0),
  .instr1(instr1), .mem0(mem0), .mem1(mem1), .result0(result0), .stall(stall),
  .loop_done(loop_done));

/* tb/integer_address_generator_tb.sv */
`timescale 1ns/1ps
module integer_address_generator_tb;
  logic                sys_clk = 1'h0;
  logic                srst = 1'h1;
  iag_pkg::iag_instr_s instr0 = '0;
  iag_pkg::iag_instr_s instr1 = '0;
  iag_pkg::iag_mem_s   mem0;
  iag_pkg::iag_mem_s   mem1;
  logic [31:0]         result0;
  logic [31:0]         result1;
  logic                stall;
  logic [1:0]          loop_done;
  logic [7:0]          n0;
  logic [7:0]          n1;
  int                  err_total = 0;
  int                  n_compared = 0;
  // Clock at 8 ns
  always #4 sys_clk = ~sys_clk;
  iag_top dut (.sys_clk(sys_clk), .srst(srst), .instr0(instr0), .instr1(instr1), .mem0(mem0),
    .mem1(mem1), .result0(result0), .result1(result1), .stall(stall), .loop_done(loop_done));
  iag_mem_bank bank0 (.sys_clk(sys_clk), .srst(srst), .req(mem0), .n_acc(n0));
  iag_mem_bank bank1 (.sys_clk(sys_clk), .srst(srst), .req(mem1), .n_acc(n1));
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Instruction with rb unused so the operand is the immediate
  function automatic iag_pkg::iag_instr_s mk(input iag_pkg::iag_op_e op, input logic [4:0] rd,
      input logic [4:0] ra, input logic [31:0] imm);
    mk = '0;
    mk.valid = 1'h1;
    mk.op = op;
    mk.rd = rd;
    mk.ra = ra;
    mk.rb = 5'h1f;
    mk.imm = imm;
  endfunction
  // Present one pair; outputs of that pair are settled on return
  task put(input iag_pkg::iag_instr_s a, input iag_pkg::iag_instr_s b);
    instr0 = a;
    instr1 = b;
    @(posedge sys_clk);
    #1;
  endtask
  task t_imm;
    iag_pkg::iag_instr_s a;
    for (int s = 0; s < 3; s++) begin
      a = mk(iag_pkg::IAG_OP_AIMM, 5'h1f, 5'h1f, 32'h0000_1000 << s);
      a.size = iag_pkg::iag_sz_e'(s);
      put(a, '0);
      cmp(mem0.addr, 32'h0000_1000 << s);
      cmp({mem0.valid, mem0.size}, {1'h1, s[1:0]});
    end
    put('0, a);
    cmp(mem1.addr, 32'h0000_4000);
    cmp({mem1.valid, mem1.size}, {1'h1, 2'h2});
  endtask
  task t_alu;
    put(mk(iag_pkg::IAG_OP_ADD, 5'h01, 5'h1f, 32'h10), '0);
    cmp(result0, 32'h10);
    put(mk(iag_pkg::IAG_OP_SUB, 5'h02, 5'h01, 32'h03), '0);
    cmp(result0, 32'h0d);
    put(mk(iag_pkg::IAG_OP_XOR, 5'h03, 5'h02, 32'hff), '0);
    cmp(result0, 32'hf2);
    put(mk(iag_pkg::IAG_OP_OR, 5'h03, 5'h02, 32'hf0), '0);
    cmp(result0, 32'hfd);
  endtask
  task t_circ;
    iag_pkg::iag_instr_s a;
    put(mk(iag_pkg::IAG_OP_SETB, 5'h1f, 5'h1f, 32'h13), '0);
    put(mk(iag_pkg::IAG_OP_SETL, 5'h1f, 5'h1f, 32'h0a), '0);
    put(mk(iag_pkg::IAG_OP_ADD, 5'h05, 5'h1f, 32'h1b), '0);
    a = mk(iag_pkg::IAG_OP_APST, 5'h1f, 5'h05, 32'h04);
    a.amode = iag_pkg::IAG_AM_CIRC;
    put(a, '0);
    cmp(mem0.addr, 32'h1b);
    put(a, '0);
    cmp(mem0.addr, 32'h15);
    a.op = iag_pkg::IAG_OP_APRE;
    put(a, '0);
    cmp(mem0.addr, 32'h13);
    a.op = iag_pkg::IAG_OP_APST;
    put(a, '0);
    cmp(mem0.addr, 32'h19);
  endtask
  // Move, mask and reverse-carry pre-modify
  task t_brev;
    iag_pkg::iag_instr_s a;
    put(mk(iag_pkg::IAG_OP_MOVI, 5'h08, 5'h1f, 32'h4000_0000), '0);
    cmp(result0, 32'h4000_0000);
    put(mk(iag_pkg::IAG_OP_AND, 5'h09, 5'h08, 32'hffff_0000), '0);
    cmp(result0, 32'h4000_0000);
    a = mk(iag_pkg::IAG_OP_APRE, 5'h1f, 5'h08, 32'h4000_0000);
    a.amode = iag_pkg::IAG_AM_BREV;
    put(a, '0);
    cmp(mem0.addr, 32'h2000_0000);
  endtask
  task t_hazard;
    put(mk(iag_pkg::IAG_OP_ADD, 5'h06, 5'h1f, 32'h20), mk(iag_pkg::IAG_OP_ADD, 5'h07, 5'h06, 32'h1));
    cmp(stall, 1'h1);
    put(mk(iag_pkg::IAG_OP_ADD, 5'h06, 5'h1f, 32'h20), mk(iag_pkg::IAG_OP_ADD, 5'h07, 5'h06, 32'h1));
    cmp(stall, 1'h0);
    cmp(result1, 32'h1);
  endtask
  task t_loop;
    put(mk(iag_pkg::IAG_OP_LSET, 5'h1f, 5'h1f, 32'h2), '0);
    put(mk(iag_pkg::IAG_OP_LDEC, 5'h1f, 5'h1f, 32'h0), '0);
    cmp(loop_done, 2'h0);
    put(mk(iag_pkg::IAG_OP_LDEC, 5'h1f, 5'h1f, 32'h0), '0);
    cmp(loop_done, 2'h1);
    put('0, mk(iag_pkg::IAG_OP_LSET, 5'h1f, 5'h1f, 32'h1));
    put('0, mk(iag_pkg::IAG_OP_LDEC, 5'h1f, 5'h1f, 32'h0));
    cmp(loop_done, 2'h2);
  endtask
  task results;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    srst = 1'h0;
    put('0, '0);
    cmp({mem0.valid, stall, loop_done}, 4'h0);
    t_imm;
    t_alu;
    t_circ;
    t_hazard;
    t_loop;
    t_brev;
    put('0, '0);
    cmp({n0, n1}, 16'h0801);
    results;
  end
endmodule // integer_address_generator_tb
